/* shared/usc_pkg.sv */
package usc_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses on the APB slave)
  // ----------------------------------------------------------------
  localparam int         USC_ADDR_W   = 4;
  localparam int         USC_DATA_W   = 32;
  localparam logic [3:0] USC_OFS_CTRL = 4'h0;
  localparam logic [3:0] USC_OFS_STAT = 4'h4;
  localparam logic [3:0] USC_OFS_DATA = 4'h8;
  localparam logic [3:0] USC_OFS_PORT = 4'hC;

  // ----------------------------------------------------------------
  // serial_control field positions
  // ----------------------------------------------------------------
  localparam int USC_CTRL_SIE   = 7;
  localparam int USC_CTRL_OIE   = 6;
  localparam int USC_CTRL_WM_HI = 5;
  localparam int USC_CTRL_WM_LO = 4;
  localparam int USC_CTRL_CS_HI = 3;
  localparam int USC_CTRL_CS_LO = 2;
  localparam int USC_CTRL_CLK   = 1;
  localparam int USC_CTRL_TC    = 0;

  // ----------------------------------------------------------------
  // status and port/direction field positions
  // ----------------------------------------------------------------
  localparam int USC_STAT_SIF    = 7;
  localparam int USC_STAT_OIF    = 6;
  localparam int USC_STAT_CNT_HI = 3;
  localparam int USC_PORT_DATA   = 0;
  localparam int USC_PORT_CLK    = 1;
  localparam int USC_DDR_DATA    = 2;
  localparam int USC_DDR_CLK     = 3;
  localparam int USC_DDR_DO      = 4;
  localparam int USC_PORT_DO     = 5;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int         USC_CNT_W    = 4;
  localparam int         USC_SR_W     = 8;
  localparam int         USC_PORT_W   = 6;
  localparam logic [3:0] USC_CNT_MAX  = 4'hF;
  localparam logic [3:0] USC_CNT_RST  = 4'h0;
  localparam logic [7:0] USC_SR_RST   = 8'h00;
  localparam logic [5:0] USC_PORT_RST = 6'h00;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    USC_WM_OFF      = 2'b00,
    USC_WM_THREE    = 2'b01,
    USC_WM_TWO      = 2'b10,
    USC_WM_TWO_HOLD = 2'b11
  } usc_wire_mode_t;

  typedef enum logic [1:0] {
    USC_CS_SOFT    = 2'b00,
    USC_CS_TIMER   = 2'b01,
    USC_CS_EXT_POS = 2'b10,
    USC_CS_EXT_NEG = 2'b11
  } usc_clk_src_t;
endpackage

/* hdl/usc_ctrl.sv */
`timescale 1ns/1ps
// How it works
// (R1) software reads and overwrites the 4-bit transfer count at any time
// (R2) count advances by one per selected clock: edge, timer, or strobe
// (R3) external source with shift strobe one: toggle strobe writes clock count
// (R4) external clock pin clocks the count even with wire mode off
// (R5) control bit 7 plus global enable raises start interrupt, even if pending
// (R6) control bit 6 plus global enable raises overflow interrupt at once
// (R7) wire mode changes outputs only; inputs work identically in all modes; the code also picks the start flag source by wire mode
// (R8) wire mode 00: no serial outputs, no hold, no start detect
// (R9) three-wire: data-out pin takes shift MSB, direction stays with DDR
// (R10) two-wire: open-collector lines, data pulled low if MSB or port zero
// (R11) two-wire clock pulled low by port zero or held after start detect
// (R12) two-wire modes disable pull-ups; line inputs unaffected
// (R13) mode 11 also holds clock low from overflow until flag cleared
// (R14) external source: output changes on opposite edge; else latch transparent
// (R15) source field and strobe bit select shift and count clocks per table
// (R16) soft source: shift strobe shifts and counts, input from previous cycle
// (R17) shift strobe bit always reads zero
// (R18) external source: shift strobe bit selects toggle strobe as count clock
// (R19) toggle strobe inverts clock port bit regardless of direction, reads 0
// (R20) overflow flag sets on 15 to 0 wrap, cleared only by writing one
// (R21) control fields reset to zero
module usc_ctrl
  import usc_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  sys_rst_in,
  // apb slave
  input  wire logic [USC_ADDR_W-1:0] paddr_in,
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [USC_DATA_W-1:0] pwdata_in,
  output logic      [USC_DATA_W-1:0] prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // system events
  input  wire logic                  timer_match_in,
  input  wire logic                  global_irq_en_in,
  input  wire logic                  start_det_in,
  // data pin (di / sda), three signals
  input  wire logic                  data_pin_in,
  output logic                       data_pin_out,
  output logic                       data_pin_oe_out,
  output logic                       data_pullup_out,
  // data-out pin (do)
  output logic                       do_pin_out,
  output logic                       do_pin_oe_out,
  // serial_clock_pin (serial_clock_pin / scl), three signals
  input  wire logic                  serial_clock_pin_in,
  output logic                       serial_clock_pin_out,
  output logic                       serial_clock_pin_oe_out,
  output logic                       clock_pullup_out,
  // interrupt requests
  output logic                       start_irq_out,
  output logic                       overflow_irq_out
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_N = 3;
  logic [SYNC_N-1:0] async_raw;
  logic [SYNC_N-1:0] sync1_q;
  logic [SYNC_N-1:0] sync2_q;

  assign async_raw = {start_det_in, serial_clock_pin_in, data_pin_in};

  // two flops per pin; stage one feeds stage two only
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= async_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic data_s;
  logic sclk_s;
  logic start_s;
  assign data_s  = sync2_q[0];
  assign sclk_s  = sync2_q[1];
  assign start_s = sync2_q[2];

  // previous samples for edge detection and soft-strobe input sampling
  logic sclk_prev_q;
  logic start_prev_q;
  logic data_prev_q;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sclk_prev_q  <= 1'b0;
      start_prev_q <= 1'b0;
      data_prev_q  <= 1'b0;
    end else begin
      sclk_prev_q  <= sclk_s;
      start_prev_q <= start_s;
      data_prev_q  <= data_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic start_rise;
  assign sclk_rise  = sclk_s & ~sclk_prev_q;
  assign sclk_fall  = ~sclk_s & sclk_prev_q;
  assign start_rise = start_s & ~start_prev_q;

  // ----------------------------------------------------------------
  // apb slave: one wait state, write takes effect with pready
  // ----------------------------------------------------------------
  logic apb_done;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic wr_port;
  logic addr_ok;
  assign apb_done = psel_in & penable_in & pready_out;
  assign wr_ctrl  = apb_done & pwrite_in & (paddr_in == USC_OFS_CTRL);
  assign wr_stat  = apb_done & pwrite_in & (paddr_in == USC_OFS_STAT);
  assign wr_data  = apb_done & pwrite_in & (paddr_in == USC_OFS_DATA);
  assign wr_port  = apb_done & pwrite_in & (paddr_in == USC_OFS_PORT);
  assign addr_ok  = (paddr_in == USC_OFS_CTRL) | (paddr_in == USC_OFS_STAT) |
                    (paddr_in == USC_OFS_DATA) | (paddr_in == USC_OFS_PORT);

  // ----------------------------------------------------------------
  // serial_control register
  // ----------------------------------------------------------------
  logic           start_ie_q;
  logic           ovf_ie_q;
  usc_wire_mode_t wm_q;
  usc_clk_src_t   cs_q;
  logic           shift_sel_q;

  // fields reset to zero; strobe bits are not stored as strobes
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      start_ie_q  <= 1'b0;                  // [R21]
      ovf_ie_q    <= 1'b0;
      wm_q        <= USC_WM_OFF;
      cs_q        <= USC_CS_SOFT;
      shift_sel_q <= 1'b0;
    end else if (wr_ctrl) begin
      start_ie_q  <= pwdata_in[USC_CTRL_SIE];
      ovf_ie_q    <= pwdata_in[USC_CTRL_OIE];
      wm_q        <= usc_wire_mode_t'(
                       pwdata_in[USC_CTRL_WM_HI:USC_CTRL_WM_LO]);
      cs_q        <= usc_clk_src_t'(
                       pwdata_in[USC_CTRL_CS_HI:USC_CTRL_CS_LO]);
      shift_sel_q <= pwdata_in[USC_CTRL_CLK]; // selector in external mode
    end
  end

  // ----------------------------------------------------------------
  // clock selection
  // ----------------------------------------------------------------
  usc_clk_src_t wr_cs;
  logic         wr_clk_bit;
  logic         wr_tc_bit;
  logic         ext_src;
  logic         shift_tick;
  logic         cnt_tick;
  logic         ext_sample_edge;
  logic         ext_output_edge;

  assign wr_cs      = usc_clk_src_t'(
                        pwdata_in[USC_CTRL_CS_HI:USC_CTRL_CS_LO]);
  assign wr_clk_bit = wr_ctrl & pwdata_in[USC_CTRL_CLK];
  assign wr_tc_bit  = wr_ctrl & pwdata_in[USC_CTRL_TC];
  assign ext_src    = cs_q[1];

  // sampling edge follows the source; the output edge is the other one
  assign ext_sample_edge = (cs_q == USC_CS_EXT_POS) ? sclk_rise : sclk_fall;
  assign ext_output_edge = (cs_q == USC_CS_EXT_POS) ? sclk_fall : sclk_rise;

  // shift and count clocks per source field and strobe bit
  always_comb begin
    shift_tick = 1'b0;
    cnt_tick   = 1'b0;
    case (cs_q)
      USC_CS_SOFT: begin
        // a write that also sets an external source is not a strobe
        shift_tick = wr_clk_bit & (wr_cs == USC_CS_SOFT);     // [R16] [R15]
        cnt_tick   = shift_tick;                               // [R2]
      end
      USC_CS_TIMER: begin
        shift_tick = timer_match_in;                           // [R15]
        cnt_tick   = timer_match_in;                           // [R2]
      end
      USC_CS_EXT_POS, USC_CS_EXT_NEG: begin
        // inputs act alike in every wire mode, so no wm_q term here
        shift_tick = ext_sample_edge;                          // [R7] [R4]
        if (shift_sel_q | wr_clk_bit)
          cnt_tick = wr_tc_bit & pwdata_in[USC_CTRL_CLK];      // [R3] [R18]
        else
          cnt_tick = sclk_rise | sclk_fall;                    // [R15] [R4]
      end
      default: begin
        shift_tick = 1'b0;
        cnt_tick   = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // serial_shift_register and output latch
  // ----------------------------------------------------------------
  logic [USC_SR_W-1:0] shreg_q;
  logic                shift_in;
  logic                out_latch_q;

  // soft and timer shifts use the input sampled one cycle earlier
  assign shift_in = ext_src ? data_s : data_prev_q;            // [R16]

  // a bus write in the same cycle as a shift wins; no shift then
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      shreg_q <= USC_SR_RST;
    end else if (wr_data) begin
      shreg_q <= pwdata_in[USC_SR_W-1:0];
    end else if (shift_tick) begin
      shreg_q <= {shreg_q[USC_SR_W-2:0], shift_in};
    end
  end

  // external: latch moves on the edge opposite sampling; else transparent
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      out_latch_q <= 1'b0;
    end else if (!ext_src || ext_output_edge) begin
      out_latch_q <= shreg_q[USC_SR_W-1];                      // [R14]
    end
  end

  // ----------------------------------------------------------------
  // transfer_count and flags
  // ----------------------------------------------------------------
  logic [USC_CNT_W-1:0] transfer_count_q;
  logic                 overflow_flag_q;
  logic                 start_flag_q;
  logic                 cnt_wrap;
  logic                 start_set;

  assign cnt_wrap = cnt_tick & (transfer_count_q == USC_CNT_MAX);

  // a direct write wins over a tick in the same cycle
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      transfer_count_q <= USC_CNT_RST;
    end else if (wr_stat) begin
      transfer_count_q <= pwdata_in[USC_STAT_CNT_HI:0];        // [R1]
    end else if (cnt_tick) begin
      transfer_count_q <= transfer_count_q + 1'b1;             // [R2]
    end
  end

  // set beats the write-one clear so a wrap is never lost
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      overflow_flag_q <= 1'b0;
    end else if (cnt_wrap) begin
      overflow_flag_q <= 1'b1;                                 // [R20]
    end else if (wr_stat && pwdata_in[USC_STAT_OIF]) begin
      overflow_flag_q <= 1'b0;                                 // [R20]
    end
  end

  // two-wire: detector; otherwise any clock-pin edge in external mode with the shift strobe bit zero
  assign start_set = wm_q[1] ? start_rise                      // [R8]
                   : (ext_src & ~shift_sel_q & (sclk_rise | sclk_fall));

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      start_flag_q <= 1'b0;
    end else if (start_set) begin
      start_flag_q <= 1'b1;
    end else if (wr_stat && pwdata_in[USC_STAT_SIF]) begin
      start_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // port and direction bits
  // ----------------------------------------------------------------
  logic [USC_PORT_W-1:0] port_q;

  // toggle strobe flips the clock port bit whatever its direction
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      port_q <= USC_PORT_RST;
    end else if (wr_port) begin
      port_q <= pwdata_in[USC_PORT_W-1:0];
    end else if (wr_tc_bit) begin
      port_q[USC_PORT_CLK] <= ~port_q[USC_PORT_CLK];           // [R19]
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic two_wire;
  logic clk_hold;
  logic data_out_d;
  logic data_oe_d;
  logic do_out_d;
  logic do_oe_d;
  logic clk_out_d;
  logic clk_oe_d;
  logic data_pu_d;
  logic clk_pu_d;

  assign two_wire = wm_q[1];
  // hold only exists in two-wire modes; mode 00 never holds
  assign clk_hold = two_wire & (start_flag_q |                 // [R11] [R8]
                    ((wm_q == USC_WM_TWO_HOLD) & overflow_flag_q)); // [R13]

  // combinational pin plan, registered below so outputs leave from flops
  always_comb begin
    // normal port operation is the default, as in mode 00
    data_out_d = port_q[USC_PORT_DATA];                        // [R8]
    data_oe_d  = port_q[USC_DDR_DATA];
    do_out_d   = port_q[USC_PORT_DO];
    do_oe_d    = port_q[USC_DDR_DO];
    clk_out_d  = port_q[USC_PORT_CLK];
    clk_oe_d   = port_q[USC_DDR_CLK];
    data_pu_d  = ~port_q[USC_DDR_DATA] & port_q[USC_PORT_DATA];
    clk_pu_d   = ~port_q[USC_DDR_CLK] & port_q[USC_PORT_CLK];
    case (wm_q)
      USC_WM_THREE: begin
        do_out_d = out_latch_q;                                // [R9]
      end
      USC_WM_TWO, USC_WM_TWO_HOLD: begin
        // open collector: drive low only, release otherwise
        data_out_d = 1'b0;
        data_oe_d  = port_q[USC_DDR_DATA] &                    // [R10]
                     (~out_latch_q | ~port_q[USC_PORT_DATA]);
        clk_out_d  = 1'b0;
        clk_oe_d   = port_q[USC_DDR_CLK] &                     // [R11]
                     (~port_q[USC_PORT_CLK] | clk_hold);
        data_pu_d  = 1'b0;                                     // [R12]
        clk_pu_d   = 1'b0;                                     // [R12]
      end
      default: begin
        do_out_d = port_q[USC_PORT_DO];
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      data_pin_out            <= 1'b0;
      data_pin_oe_out         <= 1'b0;
      do_pin_out              <= 1'b0;
      do_pin_oe_out           <= 1'b0;
      serial_clock_pin_out    <= 1'b0;
      serial_clock_pin_oe_out <= 1'b0;
      data_pullup_out         <= 1'b0;
      clock_pullup_out        <= 1'b0;
    end else begin
      data_pin_out            <= data_out_d;
      data_pin_oe_out         <= data_oe_d;
      do_pin_out              <= do_out_d;
      do_pin_oe_out           <= do_oe_d;
      serial_clock_pin_out    <= clk_out_d;
      serial_clock_pin_oe_out <= clk_oe_d;
      data_pullup_out         <= data_pu_d;
      clock_pullup_out        <= clk_pu_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  // level requests: a flag pending when the enables rise fires at once
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      start_irq_out    <= 1'b0;
      overflow_irq_out <= 1'b0;
    end else begin
      start_irq_out    <= start_flag_q & start_ie_q & global_irq_en_in; // [R5]
      overflow_irq_out <= overflow_flag_q & ovf_ie_q &
                          global_irq_en_in;                    // [R6]
    end
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  logic [USC_DATA_W-1:0] rdata_d;

  // strobe bits read as zero in control
  always_comb begin
    rdata_d = '0;
    case (paddr_in)
      USC_OFS_CTRL: begin
        rdata_d[USC_CTRL_SIE]                  = start_ie_q;
        rdata_d[USC_CTRL_OIE]                  = ovf_ie_q;
        rdata_d[USC_CTRL_WM_HI:USC_CTRL_WM_LO] = wm_q;
        rdata_d[USC_CTRL_CS_HI:USC_CTRL_CS_LO] = cs_q;         // [R17] [R19]
      end
      USC_OFS_STAT: begin
        rdata_d[USC_STAT_SIF]       = start_flag_q;
        rdata_d[USC_STAT_OIF]       = overflow_flag_q;
        rdata_d[USC_STAT_CNT_HI:0]  = transfer_count_q;        // [R1]
      end
      USC_OFS_DATA: rdata_d[USC_SR_W-1:0] = shreg_q;
      USC_OFS_PORT: rdata_d[USC_PORT_W-1:0] = port_q;
      default: rdata_d = '0;
    endcase
  end

  // pready rises in the second access cycle; data captured with it
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= '0;
      pslverr_out <= 1'b0;
    end else if (psel_in && penable_in && !pready_out) begin
      pready_out  <= 1'b1;
      prdata_out  <= pwrite_in ? '0 : rdata_d;
      pslverr_out <= ~addr_ok;
    end else begin
      pready_out  <= 1'b0;
      prdata_out  <= '0;
      pslverr_out <= 1'b0;
    end
  end

endmodule

/* verification/usc_ctrl_assertions.sv */
`timescale 1ns/1ps
module usc_ctrl_checker
  import usc_pkg::*;
(
  // clock, reset and apb
  input logic        mclk_in,
  input logic        sys_rst_in,
  input logic [3:0]  paddr_in,
  input logic        psel_in,
  input logic        penable_in,
  input logic        pwrite_in,
  input logic [31:0] pwdata_in,
  input logic [31:0] prdata_out,
  input logic        pready_out,
  input logic        pslverr_out,
  // events and observed outputs
  input logic        global_irq_en_in,
  input logic        data_pullup_out,
  input logic        clock_pullup_out,
  input logic        start_irq_out,
  input logic        overflow_irq_out
);
  // ----
  // helpers
  // ----
  logic [5:0] ctl_q;
  logic       tw_q;
  logic       wr_ctl;
  // mirror of control bits 7:2, taken at the completing edge only
  assign wr_ctl = psel_in & penable_in & pready_out & pwrite_in
                & (paddr_in == USC_OFS_CTRL);
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ctl_q <= 6'h00;
      tw_q  <= 1'b0;
    end else begin
      if (wr_ctl) ctl_q <= pwdata_in[7:2];
      tw_q <= ctl_q[3];
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // ----
  // properties
  // ----
  property p_rdy_wait;
    psel_in && penable_in && !pready_out |=> pready_out;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait)
    else $error("no ready after access");
  property p_rdy_pulse;
    pready_out |=> !pready_out;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready longer than one cycle");
  property p_rd_idle;
    !pready_out |-> prdata_out == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside answer");
  property p_err;
    pready_out |-> pslverr_out == (paddr_in[1:0] != 2'b00);
  endproperty
  a_err: assert property (p_err)
    else $error("slave error wrong");
  property p_ctrl_rd;
    pready_out && !pwrite_in && paddr_in == USC_OFS_CTRL
      |-> prdata_out[7:0] == {ctl_q, 2'b00};
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control read back wrong");
  property p_irq_gen;
    !$past(global_irq_en_in) |-> !start_irq_out && !overflow_irq_out;
  endproperty
  a_irq_gen: assert property (p_irq_gen)
    else $error("interrupt without global enable");
  property p_pullup;
    ctl_q[3] && tw_q |-> !data_pullup_out && !clock_pullup_out;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up on in two-wire mode");
  property p_rst;
    disable iff (1'b0)
    sys_rst_in |=> !pready_out && !start_irq_out && !overflow_irq_out;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared by reset");
  // main scenarios reached
  c_ovf: cover property (overflow_irq_out);
  c_start: cover property (start_irq_out);
  c_err: cover property (pslverr_out);
endmodule
bind usc_ctrl usc_ctrl_checker chk_i (.*);

/* verification/usc_peer_model.sv */
`timescale 1ns/1ps
module usc_peer_model (
  // device side of the two lines
  input  wire logic sda_oe_in,
  input  wire logic sda_drv_in,
  input  wire logic scl_oe_in,
  input  wire logic scl_drv_in,
  input  wire logic two_wire_in,
  // resolved line levels
  output logic      sda_line_out,
  output logic      scl_line_out
);
  logic clk_q = 1'b0;
  logic dat_q = 1'b1;
  // a driving device wins; released lines show the peer
  assign sda_line_out = sda_oe_in ? sda_drv_in : dat_q;
  assign scl_line_out = scl_oe_in ? scl_drv_in : clk_q;
  // master frame: data moves while clock is low, clock idles low
  task automatic frame(input int cyc, input logic [7:0] b);
    #3;
    for (int i = 0; i < cyc; i++) begin
      dat_q = b[7-i];
      #62.5 clk_q = 1'b1;
      #62.5 clk_q = 1'b0;
    end
    // released data goes high in two-wire mode and flips from the last bit otherwise
    dat_q = two_wire_in ? 1'b1 : ~dat_q;
  endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import usc_pkg::*;
;
  // ----
  // signals and instances
  // ----
  logic        mclk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [3:0]  paddr_in = 4'h0;
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out, rv;
  logic        pready_out, pslverr_out, er, ge;
  logic        timer_match_in = 1'b0, global_irq_en_in = 1'b0;
  logic        start_det_in = 1'b0, two_wire = 1'b0;
  logic        data_pin_in, data_pin_out, data_pin_oe_out;
  logic        data_pullup_out, do_pin_out, do_pin_oe_out;
  logic        serial_clock_pin_in, serial_clock_pin_out;
  logic        serial_clock_pin_oe_out, clock_pullup_out;
  logic        start_irq_out, overflow_irq_out;
  logic [31:0] seed = 32'hF94A;
  int          mismatches = 0, checks = 0, k, m;
  usc_ctrl uut (.*);
  usc_peer_model peer (.sda_oe_in(data_pin_oe_out), .sda_drv_in(data_pin_out),
    .scl_oe_in(serial_clock_pin_oe_out), .scl_drv_in(serial_clock_pin_out),
    .two_wire_in(two_wire), .sda_line_out(data_pin_in),
    .scl_line_out(serial_clock_pin_in));
  // free-running system clock
  always #4 mclk_in = ~mclk_in;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // bits shifted in by m positive edges of a byte sent msb first
  function automatic logic [31:0] shifted(input int m, input logic [7:0] b);
    return {24'h0, b >> (8 - m)};
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t word %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t bit %b expected %b", $time, g, e);
    end
  endtask
  // one apb transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rv = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      $display("[FAIL] %0t bus timeout", $time);
      finish_test();
    end
    @(posedge mclk_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic tick();
    timer_match_in <= 1'b1;
    @(posedge mclk_in);
    timer_match_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    rd(USC_OFS_CTRL, 32'h0);
    rd(4'h2, 32'h0);
    chkb(er, 1'b1);
    for (int i = 0; i < 4; i++) begin
      seed = nxt(seed);
      wr(USC_OFS_STAT, {28'h0, seed[3:0]});
      rd(USC_OFS_STAT, {28'h0, seed[3:0]});
    end
    // software strobe across the wrap, overflow interrupt and clear
    ge = seed[4];
    global_irq_en_in <= ge;
    wr(USC_OFS_STAT, 32'hE);
    wr(USC_OFS_CTRL, 32'h42);
    wr(USC_OFS_CTRL, 32'h42);
    rd(USC_OFS_CTRL, 32'h40);
    rd(USC_OFS_STAT, 32'h40);
    chkb(overflow_irq_out, ge);
    wr(USC_OFS_STAT, 32'h40);
    rd(USC_OFS_STAT, 32'h0);
    // timer source counts matches, strobe bit is a don't-care
    seed = nxt(seed);
    k = 1 + seed[1:0];
    wr(USC_OFS_CTRL, {28'h0, 2'b01, seed[8], 1'b0});
    repeat (k) tick();
    rd(USC_OFS_STAT, k);
    // external source: timer ignored, toggle strobe counts and flips
    wr(USC_OFS_CTRL, 32'h08);
    tick();
    wr(USC_OFS_CTRL, 32'h0B);
    rd(USC_OFS_STAT, k + 1);
    rd(USC_OFS_PORT, 32'h02);
    // external clock both edges with outputs off, data shifted in
    wr(USC_OFS_CTRL, 32'h08);
    wr(USC_OFS_STAT, 32'hC0);
    wr(USC_OFS_DATA, 32'h0);
    seed = nxt(seed);
    m = 1 + (seed[7:0] % 7);
    peer.frame(m, seed[15:8]);
    repeat (8) @(posedge mclk_in);
    rd(USC_OFS_STAT, 32'h80 | (2 * m));
    rd(USC_OFS_DATA, shifted(m, seed[15:8]));
    ge = seed[16];
    global_irq_en_in <= ge;
    wr(USC_OFS_CTRL, 32'h88);
    repeat (2) @(posedge mclk_in);
    chkb(start_irq_out, ge);
    // three-wire: data-out pin follows the shift msb
    wr(USC_OFS_PORT, 32'h10);
    wr(USC_OFS_CTRL, 32'h10);
    for (int v = 0; v < 2; v++) begin
      wr(USC_OFS_DATA, {24'h0, v[0], 7'h0});
      repeat (4) @(posedge mclk_in);
      chkb(do_pin_out, v[0]);
      chkb(do_pin_oe_out, 1'b1);
    end
    // two-wire modes: data pulled low, overflow hold only in mode 11
    two_wire <= 1'b1;
    wr(USC_OFS_PORT, 32'h0E);
    for (int md = 2; md < 4; md++) begin
      wr(USC_OFS_STAT, 32'hCF);
      wr(USC_OFS_CTRL, {26'h0, md[1:0], 4'h4});
      tick();
      repeat (2) @(posedge mclk_in);
      chkb(serial_clock_pin_oe_out, md == 3);
      chkb(data_pin_oe_out, 1'b1);
      wr(USC_OFS_STAT, 32'h40);
      repeat (3) @(posedge mclk_in);
      chkb(serial_clock_pin_oe_out, 1'b0);
    end
    start_det_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    chkb(serial_clock_pin_oe_out, 1'b1);
    chkb(serial_clock_pin_out, 1'b0);
    finish_test();
  end
endmodule
